// ### asp_pkg.sv
// asp_pkg: constants, types and timing arithmetic for the async sram host port.
// assumes a single 20 MHz clock and a 32k x 8 asynchronous static ram on the pins.
package asp_pkg;

  localparam int ASP_INDEX_W      = 15;
  localparam int ASP_DATA_W       = 8;
  localparam int ASP_WORDS        = 32768;
  localparam int ASP_CLK_PERIOD_NS = 50;
  localparam int ASP_GRADES       = 3;

  // per speed grade, fastest first; the four scalar limits after the arrays apply to every grade
  localparam int ASP_ADDR_ACCESS_MAX_NS[ASP_GRADES]     = '{12, 15, 20};
  localparam int ASP_SEL_ACCESS_MAX_NS[ASP_GRADES]      = '{12, 15, 20};
  localparam int ASP_OE_ACCESS_MAX_NS[ASP_GRADES]       = '{6, 7, 8};
  localparam int ASP_DESELECT_TO_FLOAT_MAX_NS[ASP_GRADES] = '{8, 9, 10};
  localparam int ASP_OE_TO_FLOAT_MAX_NS[ASP_GRADES]     = '{6, 7, 8};
  localparam int ASP_STROBE_TO_FLOAT_MAX_NS[ASP_GRADES] = '{8, 9, 10};
  localparam int ASP_WRITE_PULSE_MIN_NS[ASP_GRADES]     = '{9, 10, 15};
  localparam int ASP_INDEX_TO_END_MIN_NS[ASP_GRADES]    = '{9, 10, 15};
  localparam int ASP_SEL_TO_END_MIN_NS[ASP_GRADES]      = '{9, 10, 15};
  localparam int ASP_DATA_OVERLAP_MIN_NS[ASP_GRADES]    = '{6, 7, 8};
  localparam int ASP_INDEX_SETUP_MIN_NS  = 0;
  localparam int ASP_DATA_HOLD_MIN_NS    = 0;
  localparam int ASP_WRITE_RECOVERY_MIN_NS = 0;
  localparam int ASP_INDEX_CHANGE_HOLD_MIN_NS = 3;

  typedef enum logic [2:0] {
    ASP_IDLE      = 3'b000,
    ASP_WR_SETUP  = 3'b001,
    ASP_WR_STROBE = 3'b010,
    ASP_WR_HOLD   = 3'b011,
    ASP_RD_ACCESS = 3'b100,
    ASP_TURN      = 3'b101
  } asp_state_e;

  typedef struct packed {
    logic                  sel_n;
    logic                  strobe_n;
    logic                  drive_en_n;
    logic [ASP_INDEX_W-1:0] word_index;
    logic [ASP_DATA_W-1:0]  wdata;
    logic                  wdata_oe;
  } asp_pins_s;

  localparam asp_pins_s ASP_PINS_RST = '{
    sel_n: 1'b1, strobe_n: 1'b1, drive_en_n: 1'b1,
    word_index: '0, wdata: '0, wdata_oe: 1'b0
  };

  // whole clock periods, rounded up, never below one
  function automatic int asp_cycles(input int ns);
    int c;
    c = (ns + ASP_CLK_PERIOD_NS - 1) / ASP_CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int asp_max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

endpackage

// ### asp_ctrl.sv
// asp_ctrl: clocked host that runs single reads and writes on an async 32k x 8 sram.
// assumes the ram pins are wired straight to this block and the user side is synchronous.
// Summary of operation
// - strobe stays high through every read access
// - a write lasts only while select and strobe are both low
// - strobe low time covers pulse minimum, or float plus overlap when enable low
// - host never drives write data while the device may still drive
// - write index stable 9/10/15 ns before write end, zero setup
// - select held low 9/10/15 ns before write end
// - write data stable 6/7/8 ns before write end, zero hold
// - recovery counted from earlier of select or strobe rising
// - index changes only while strobe or select is high
`timescale 1ns/1ns
module asp_ctrl
  import asp_pkg::*;
#(
  parameter int GRADE = 2,
  parameter int CNT_W = 4
) (
  input  wire logic                   clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   req_valid_i,
  input  wire logic                   req_write_i,
  input  wire logic [ASP_INDEX_W-1:0] req_index_i,
  input  wire logic [ASP_DATA_W-1:0]  req_wdata_i,
  output logic                        req_ready_o,
  output logic                        rsp_valid_o,
  output logic [ASP_DATA_W-1:0]       rsp_rdata_o,
  output logic                        sel_n_o,
  output logic                        strobe_n_o,
  output logic                        drive_en_n_o,
  output logic [ASP_INDEX_W-1:0]      word_index_o,
  input  wire logic [ASP_DATA_W-1:0]  shared_byte_lines_i,
  output logic [ASP_DATA_W-1:0]       shared_byte_lines_o,
  output logic                        shared_byte_lines_oe_o
);

  // interval counts
  // output enable stays high during writes, so the plain pulse minimum governs the strobe
  localparam int WR_SETUP_CYC = asp_cycles(ASP_INDEX_SETUP_MIN_NS);
  localparam int WR_PULSE_CYC = asp_cycles(asp_max2(
      asp_max2(ASP_WRITE_PULSE_MIN_NS[GRADE], ASP_DATA_OVERLAP_MIN_NS[GRADE]),
      asp_max2(ASP_INDEX_TO_END_MIN_NS[GRADE], ASP_SEL_TO_END_MIN_NS[GRADE])));
  localparam int WR_HOLD_CYC  = asp_cycles(asp_max2(ASP_DATA_HOLD_MIN_NS,
                                                    ASP_WRITE_RECOVERY_MIN_NS));
  localparam int RD_CYC       = asp_cycles(asp_max2(
      asp_max2(ASP_ADDR_ACCESS_MAX_NS[GRADE], ASP_SEL_ACCESS_MAX_NS[GRADE]),
      ASP_OE_ACCESS_MAX_NS[GRADE]));
  localparam int TURN_CYC     = asp_cycles(asp_max2(ASP_DESELECT_TO_FLOAT_MAX_NS[GRADE],
                                                    ASP_OE_TO_FLOAT_MAX_NS[GRADE]));
  localparam int MAX_CYC      = asp_max2(asp_max2(WR_PULSE_CYC, RD_CYC),
                                         asp_max2(TURN_CYC, asp_max2(WR_SETUP_CYC,
                                                                     WR_HOLD_CYC)));

  if (GRADE < 0 || GRADE >= ASP_GRADES) begin : g_bad_grade
    $error("asp_ctrl: GRADE out of range");
  end
  if (MAX_CYC > (1 << CNT_W)) begin : g_bad_cnt
    $error("asp_ctrl: CNT_W too narrow for timing counts");
  end
  if ((1 << ASP_INDEX_W) != ASP_WORDS) begin : g_bad_words
    $error("asp_ctrl: index width does not span the array");
  end

  localparam logic [CNT_W-1:0] WR_SETUP_LD = CNT_W'(WR_SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] WR_PULSE_LD = CNT_W'(WR_PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] WR_HOLD_LD  = CNT_W'(WR_HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] RD_LD       = CNT_W'(RD_CYC - 1);
  localparam logic [CNT_W-1:0] TURN_LD     = CNT_W'(TURN_CYC - 1);

  // counters load n-1 and run down;
  // zero marks the last cycle, so a count of one still spans a full cycle
  function automatic logic cnt_last(input logic [CNT_W-1:0] c);
    return (c == '0);
  endfunction

  asp_state_e              state_ff, nxt_state;
  logic [CNT_W-1:0]        cnt_ff, nxt_cnt;
  asp_pins_s               pins_ff, nxt_pins;
  logic                    ready_ff, nxt_ready;
  logic                    rsp_valid_ff, nxt_rsp_valid;
  logic [ASP_DATA_W-1:0]   rsp_rdata_ff, nxt_rsp_rdata;

  always_comb begin
    nxt_state     = state_ff;
    nxt_cnt       = cnt_ff;
    nxt_pins      = pins_ff;
    nxt_ready     = 1'b0;
    nxt_rsp_valid = 1'b0;
    nxt_rsp_rdata = rsp_rdata_ff;
    case (state_ff)
      ASP_IDLE: begin
        nxt_ready = 1'b1;
        if (req_valid_i && ready_ff) begin
          nxt_ready           = 1'b0;
          nxt_pins.word_index = req_index_i;
          nxt_pins.sel_n      = 1'b0;
          nxt_pins.strobe_n   = 1'b1;
          if (req_write_i) begin
            nxt_pins.drive_en_n = 1'b1;
            nxt_pins.wdata      = req_wdata_i;
            nxt_state           = ASP_WR_SETUP;
            nxt_cnt             = WR_SETUP_LD;
          end else begin
            nxt_pins.drive_en_n = 1'b0;
            nxt_state           = ASP_RD_ACCESS;
            nxt_cnt             = RD_LD;
          end
        end
      end
      ASP_WR_SETUP: begin
        if (!cnt_last(cnt_ff)) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else begin
          // data driven only with enable high
          nxt_pins.strobe_n = 1'b0;
          nxt_pins.wdata_oe = 1'b1;
          nxt_state         = ASP_WR_STROBE;
          nxt_cnt           = WR_PULSE_LD;
        end
      end
      ASP_WR_STROBE: begin
        if (!cnt_last(cnt_ff)) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else begin
          nxt_pins.strobe_n = 1'b1;
          nxt_state         = ASP_WR_HOLD;
          nxt_cnt           = WR_HOLD_LD;
        end
      end
      ASP_WR_HOLD: begin
        if (!cnt_last(cnt_ff)) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else begin
          nxt_pins.sel_n    = 1'b1;
          nxt_pins.wdata_oe = 1'b0;
          nxt_state         = ASP_IDLE;
          nxt_ready         = 1'b1;
        end
      end
      ASP_RD_ACCESS: begin
        if (!cnt_last(cnt_ff)) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else begin
          nxt_rsp_rdata       = shared_byte_lines_i;
          nxt_rsp_valid       = 1'b1;
          nxt_pins.sel_n      = 1'b1;
          nxt_pins.drive_en_n = 1'b1;
          nxt_state           = ASP_TURN;
          nxt_cnt             = TURN_LD;
        end
      end
      ASP_TURN: begin
        if (!cnt_last(cnt_ff)) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else begin
          nxt_state = ASP_IDLE;
          nxt_ready = 1'b1;
        end
      end
      default: begin
        nxt_state = ASP_IDLE;
        nxt_cnt   = '0;
        nxt_pins  = ASP_PINS_RST;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff     <= ASP_IDLE;
      cnt_ff       <= '0;
      pins_ff      <= ASP_PINS_RST;
      ready_ff     <= 1'b1;
      rsp_valid_ff <= 1'b0;
      rsp_rdata_ff <= '0;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      pins_ff      <= nxt_pins;
      ready_ff     <= nxt_ready;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_rdata_ff <= nxt_rsp_rdata;
    end
  end

  assign sel_n_o                = pins_ff.sel_n;
  assign strobe_n_o             = pins_ff.strobe_n;
  assign drive_en_n_o           = pins_ff.drive_en_n;
  assign word_index_o           = pins_ff.word_index;
  assign shared_byte_lines_o    = pins_ff.wdata;
  assign shared_byte_lines_oe_o = pins_ff.wdata_oe;
  assign req_ready_o            = ready_ff;
  assign rsp_valid_o            = rsp_valid_ff;
  assign rsp_rdata_o            = rsp_rdata_ff;

endmodule

// ### asp_ctrl_checker.sv
// asp_chk: pin protocol assertions for the sram host port.
// assumes it is bound onto asp_ctrl and sees one clock domain.
`timescale 1ns/1ns
module asp_chk
  import asp_pkg::*;
(
  input wire logic                   clk_i,
  input wire logic                   reset_n_i,
  input wire logic                   req_valid_i,
  input wire logic                   req_write_i,
  input wire logic [ASP_INDEX_W-1:0] req_index_i,
  input wire logic                   req_ready_o,
  input wire logic                   rsp_valid_o,
  input wire logic [ASP_DATA_W-1:0]  rsp_rdata_o,
  input wire logic                   sel_n_o,
  input wire logic                   strobe_n_o,
  input wire logic                   drive_en_n_o,
  input wire logic [ASP_INDEX_W-1:0] word_index_o,
  input wire logic [ASP_DATA_W-1:0]  shared_byte_lines_i,
  input wire logic [ASP_DATA_W-1:0]  shared_byte_lines_o,
  input wire logic                   shared_byte_lines_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic take;
  assign take = req_valid_i && req_ready_o;
  sequence s_wr;
    !sel_n_o && strobe_n_o ##1 !sel_n_o && !strobe_n_o && shared_byte_lines_oe_o
    ##1 !sel_n_o && strobe_n_o ##1 sel_n_o && !shared_byte_lines_oe_o && req_ready_o;
  endsequence
  sequence s_rd;
    !sel_n_o && !drive_en_n_o && strobe_n_o ##1 sel_n_o && drive_en_n_o && rsp_valid_o
    ##1 !rsp_valid_o && req_ready_o;
  endsequence
  property p_wr_walk; take && req_write_i |=> s_wr; endproperty
  property p_rd_walk; take && !req_write_i |=> s_rd; endproperty
  property p_rd_no_wr; !drive_en_n_o |-> strobe_n_o; endproperty
  property p_wr_oe_off; !strobe_n_o |-> drive_en_n_o && !sel_n_o; endproperty
  property p_no_clash; shared_byte_lines_oe_o |-> drive_en_n_o && $past(drive_en_n_o); endproperty
  property p_idx; take |=> word_index_o == $past(req_index_i); endproperty
  property p_idx_hold; !sel_n_o && !$past(sel_n_o) |-> $stable(word_index_o); endproperty
  property p_sel_first; $fell(strobe_n_o) |-> !$past(sel_n_o); endproperty
  property p_data_hold; $rose(strobe_n_o) |-> shared_byte_lines_oe_o && $stable(shared_byte_lines_o);
  endproperty
  property p_rdata; rsp_valid_o |-> rsp_rdata_o == $past(shared_byte_lines_i); endproperty
  a_wr_walk: assert property (p_wr_walk) else $error("write pin walk wrong");
  a_rd_walk: assert property (p_rd_walk) else $error("read pin walk wrong");
  a_rd_no_wr: assert property (p_rd_no_wr) else $error("strobe low in read");
  a_wr_oe_off: assert property (p_wr_oe_off) else $error("enable low in write");
  a_no_clash: assert property (p_no_clash) else $error("host drives too early");
  a_idx: assert property (p_idx) else $error("index not presented");
  a_idx_hold: assert property (p_idx_hold) else $error("index moved while selected");
  a_sel_first: assert property (p_sel_first) else $error("select not low before strobe");
  a_data_hold: assert property (p_data_hold) else $error("write data moved at end");
  a_rdata: assert property (p_rdata) else $error("read data not from lines");
endmodule
bind asp_ctrl asp_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i),
  .req_write_i(req_write_i), .req_index_i(req_index_i), .req_ready_o(req_ready_o),
  .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .sel_n_o(sel_n_o),
  .strobe_n_o(strobe_n_o), .drive_en_n_o(drive_en_n_o), .word_index_o(word_index_o),
  .shared_byte_lines_i(shared_byte_lines_i), .shared_byte_lines_o(shared_byte_lines_o),
  .shared_byte_lines_oe_o(shared_byte_lines_oe_o));

// ### asp_sram_model.sv
// asp_sram_model: behavioural 32k x 8 async ram.
// assumes the bench resolves the shared lines from the host enable alone.
`timescale 1ns/1ns
module asp_sram_model
  import asp_pkg::*;
#(
  parameter int ACC_NS = 20
) (
  input  wire logic                   sel_n_i,
  input  wire logic                   strobe_n_i,
  input  wire logic                   drive_en_n_i,
  input  wire logic [ASP_INDEX_W-1:0] word_index_i,
  input  wire logic [ASP_DATA_W-1:0]  lines_i,
  output logic [ASP_DATA_W-1:0]       lines_o,
  output logic                        lines_oe_o
);
  logic [ASP_DATA_W-1:0] mem [ASP_WORDS];
  logic [ASP_DATA_W-1:0] rd_val;
  logic [ASP_DATA_W-1:0] last = 8'hA5;
  logic                  rd_on;
  assign rd_on = !sel_n_i && strobe_n_i && !drive_en_n_i;
  assign #(ACC_NS, 0) lines_oe_o = rd_on;
  // old data stays while the new word settles
  assign #(ACC_NS) rd_val = mem[word_index_i];
  // released lines invert the last value, so a stale sample shows
  assign lines_o = lines_oe_o ? rd_val : ~last;
  always @(negedge lines_oe_o) last = rd_val;
  // store when the first of select or strobe rises
  always @(posedge strobe_n_i or posedge sel_n_i) begin
    if (!strobe_n_i || !sel_n_i) mem[word_index_i] = lines_i;
  end
endmodule

// ### asp_ctrl_tb.sv
// asp_ctrl_tb: directed tests of the sram host port.
// assumes the behavioural ram on the far side and a 20 MHz clock.
`timescale 1ns/1ns
module asp_ctrl_tb
  import asp_pkg::*;
;
  logic                   clk, rst_n, v, w, ready, rv, sel_n, stb_n, den_n, oe, m_oe;
  logic [ASP_INDEX_W-1:0] idx, widx;
  logic [ASP_DATA_W-1:0]  wd, rd, dq, hd, md;
  int                     mismatches = 0;
  int                     n_checks = 0;
  assign dq = oe ? hd : md;
  asp_ctrl dut (.clk_i(clk), .reset_n_i(rst_n), .req_valid_i(v), .req_write_i(w),
    .req_index_i(idx), .req_wdata_i(wd), .req_ready_o(ready), .rsp_valid_o(rv),
    .rsp_rdata_o(rd), .sel_n_o(sel_n), .strobe_n_o(stb_n), .drive_en_n_o(den_n),
    .word_index_o(widx), .shared_byte_lines_i(dq), .shared_byte_lines_o(hd),
    .shared_byte_lines_oe_o(oe));
  asp_sram_model ram (.sel_n_i(sel_n), .strobe_n_i(stb_n), .drive_en_n_i(den_n),
    .word_index_i(widx), .lines_i(dq), .lines_o(md), .lines_oe_o(m_oe));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic req(input logic wr, input logic [14:0] i, input logic [7:0] d);
    @(negedge clk);
    while (!ready) @(negedge clk);
    @(posedge clk);
    v <= 1'b1;
    w <= wr;
    idx <= i;
    wd <= d;
    @(posedge clk);
    v <= 1'b0;
  endtask
  task automatic rd_chk(input logic [14:0] i, input logic [7:0] e);
    int n;
    req(1'b0, i, 8'h00);
    n = 0;
    @(negedge clk);
    // only the ram drives in a read
    chk({m_oe, oe}, 2'b10);
    while (!rv && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk({rv, rd}, {1'b1, e});
  endtask
  task automatic t_rw();
    logic [14:0] ix [4] = '{15'h0000, 15'h7FFF, 15'h2AAA, 15'h5555};
    logic [7:0]  dt [4] = '{8'h3C, 8'hC3, 8'h00, 8'hFF};
    foreach (ix[k]) req(1'b1, ix[k], dt[k]);
    foreach (ix[k]) rd_chk(ix[k], dt[k]);
    $display("test rw done");
  endtask
  task automatic t_refused();
    req(1'b1, 15'h0100, 8'h11);
    req(1'b1, 15'h0200, 8'h22);
    @(posedge clk);
    v <= 1'b1;
    idx <= 15'h0100;
    wd <= 8'h99;
    repeat (2) @(posedge clk);
    v <= 1'b0;
    rd_chk(15'h0100, 8'h11);
    rd_chk(15'h0200, 8'h22);
    $display("test refused done");
  endtask
  task automatic t_midreset();
    req(1'b1, 15'h0000, 8'hEE);
    // abort in the setup cycle after the take, before the strobe can fall
    rst_n <= 1'b0;
    #1;
    chk({sel_n, stb_n, oe, ready}, 4'hD);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(15'h0000, 8'h3C);
    $display("test midreset done");
  endtask
  initial begin
    rst_n = 1'b0;
    v = 1'b0;
    w = 1'b0;
    idx = '0;
    wd = '0;
    repeat (10) @(negedge clk);
    chk({sel_n, stb_n, den_n, oe, ready, rv}, 16'h003A);
    $display("test reset done");
    @(posedge clk);
    rst_n <= 1'b1;
    t_rw();
    t_refused();
    t_midreset();
    summarize();
  end
  initial begin
    #(1000 * 50);
    mismatches++;
    summarize();
  end
endmodule
